// ---- pkg/bag_pkg.sv ----
// Package with constants, types and descriptor layout for the buffer address generator
package bag_pkg;

	// Descriptor field positions
	localparam int BASE_LSB       = 0;
	localparam int BASE_W         = 48;
	localparam int STRIDE_LSB     = 48;
	localparam int STRIDE_W       = 14;
	localparam int SWZ_EN_BIT     = 63;
	localparam int NUMREC_LSB     = 64;
	localparam int NUMREC_W       = 32;
	localparam int SEL_LSB        = 96;
	localparam int SEL_W          = 3;
	localparam int IDX_GRP_LSB    = 117;
	localparam int ADD_LANE_BIT   = 119;
	localparam int BOUNDS_LSB     = 124;
	localparam int TYPE_LSB       = 126;

	// Fixed transfer unit and lane widths
	localparam int UNIT_BYTES     = 4;
	localparam int UNIT_SHIFT     = 2;
	localparam int LANE_W         = 6;
	localparam int HALF_W         = 16;
	localparam int LSHARE_GRAN_SH = 7;   // 32 words = 128 bytes
	localparam int ADDR_W         = 48;

	// Register bus map, byte addresses
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_LSBASE = 8'h08;
	localparam logic [7:0] OFS_LSSIZE = 8'h0C;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

	// Responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Alignment policy codes
	typedef enum logic [1:0] {
		ALIGN_WORD   = 2'h0,
		ALIGN_STRICT_WORD = 2'h1,
		ALIGN_STRICT = 2'h2,
		ALIGN_NONE   = 2'h3
	} bag_align_t;

	// Operation kinds
	typedef enum logic [1:0] {
		OP_LOAD   = 2'h0,
		OP_STORE  = 2'h1,
		OP_ATOMIC = 2'h2
	} bag_op_t;

	// Channel select values
	localparam logic [2:0] SEL_ZERO = 3'h0;
	localparam logic [2:0] SEL_ONE  = 3'h1;
	localparam logic [2:0] SEL_R    = 3'h4;
	localparam logic [2:0] SEL_G    = 3'h5;
	localparam logic [2:0] SEL_B    = 3'h6;
	localparam logic [2:0] SEL_A    = 3'h7;

	// Cache policies
	typedef enum logic [2:0] {
		POL_LRU        = 3'h0,
		POL_HIT_LRU    = 3'h1,
		POL_MISS_EVICT = 3'h2,
		POL_STREAM     = 3'h3,
		POL_HIT_NOALLOC = 3'h4,
		POL_BYPASS     = 3'h5
	} bag_pol_t;

	// One lane request from the shader core
	typedef struct packed {
		bag_op_t      op;
		logic         formatted;
		logic         half_word_low_variant;
		logic         half_word_high_variant;
		logic         byte_load;
		logic         to_local_share;
		logic         fault_status_enable;
		logic         idx_from_reg;
		logic         off_from_reg;
		logic         bypass_first;
		logic         system_coherence_flag;
		logic         device_coherence_flag;
		logic [2:0]   size_log2;
		logic [5:0]   lane_index;
		logic [11:0]  imm_offset;
		logic [31:0]  lane_idx;
		logic [31:0]  lane_off;
		logic [31:0]  scalar_off;
		logic [31:0]  data;
		logic [127:0] desc;
	} bag_req_t;

	// Result towards the cache
	typedef struct packed {
		logic [47:0]  mem_addr;
		logic [31:0]  local_addr;
		logic         local_ok;
		logic         unbound;
		logic         align_fault;
		logic         return_data;
		logic         first_invalidate;
		bag_pol_t     pol_l2;
		bag_pol_t     pol_l1;
		bag_pol_t     pol_l0;
		logic [1:0]   bounds_sel;
		logic         is_buffer;
		logic [31:0]  num_records;
		logic         rec_in_bytes;
		logic [11:0]  sels;
		logic [31:0]  wdata;
	} bag_res_t;

endpackage : bag_pkg

// ---- rtl/bag_core.sv ----
// Buffer address generator with AXI4-Lite control registers
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module bag_core
	import bag_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Request from shader core
	input  wire logic        req_valid,
	input  bag_req_t         req,
	// Result towards cache
	output logic             res_valid,
	output bag_res_t         res
);

	// Control registers
	logic [31:0] ctrl;
	logic [31:0] ls_base;
	logic [31:0] ls_size;
	logic [15:0] local_offset_register;
	logic [31:0] req_count;
	logic [31:0] fault_count;

	bag_align_t alignment_policy;
	assign alignment_policy = bag_align_t'(ctrl[1:0]);
	assign local_offset_register = ctrl[31:16];

	// Descriptor fields
	logic [47:0] d_base;
	logic [13:0] d_stride;
	logic        d_swz;
	logic [31:0] d_numrec;
	logic [1:0]  d_grp_code;
	logic        d_add_lane;
	logic [1:0]  d_bounds;
	logic [1:0]  d_type;
	logic        d_unbound;
	logic [6:0]  grp_shift;

	always_comb begin
		d_base     = req.desc[BASE_LSB +: BASE_W];
		d_stride   = req.desc[STRIDE_LSB +: STRIDE_W];
		d_swz      = req.desc[SWZ_EN_BIT];
		d_numrec   = req.desc[NUMREC_LSB +: NUMREC_W];
		d_grp_code = req.desc[IDX_GRP_LSB +: 2];
		d_add_lane = req.desc[ADD_LANE_BIT];
		d_bounds   = req.desc[BOUNDS_LSB +: 2];
		d_type     = req.desc[TYPE_LSB +: 2];
		d_unbound  = (req.desc == '0);
		grp_shift  = 7'(3 + d_grp_code);
	end

	// Channel selects, kept only when legal codes
	logic [11:0] sels;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sel
			logic [2:0] s;
			assign s = req.desc[SEL_LSB + gi*SEL_W +: SEL_W];
			// Unknown codes read as constant zero
			assign sels[gi*3 +: 3] = (s == SEL_ONE || s >= SEL_R) ? s : SEL_ZERO;
		end
	endgenerate

	// Index and offset forming
	logic [32:0] idx;
	logic [32:0] off;
	logic [32:0] mem_idx;
	logic [6:0]  grp_size;

	always_comb begin
		mem_idx = {1'b0, (req.idx_from_reg ? req.lane_idx : 32'h0000_0000)};
		if (d_add_lane)
			mem_idx = mem_idx + {27'h0, req.lane_index};
		idx = mem_idx;
		off = {1'b0, (req.off_from_reg ? req.lane_off : 32'h0000_0000)}
			+ {21'h0, req.imm_offset};
		grp_size = 7'(7'h01 << grp_shift[2:0]);
	end

	// Swizzle or linear buffer offset
	logic [47:0] idx_q;
	logic [47:0] idx_r;
	logic [47:0] off_q;
	logic [47:0] off_r;
	logic [47:0] buf_off;

	always_comb begin
		idx_q = 48'(idx >> grp_shift[2:0]);
		idx_r = 48'(idx) & 48'(grp_size - 7'h01);
		off_q = 48'(off >> UNIT_SHIFT);
		off_r = 48'(off) & 48'(UNIT_BYTES - 1);
		if (d_swz)
			buf_off = 48'(((idx_q * 48'(d_stride) + (off_q << UNIT_SHIFT)) << grp_shift[2:0])
				+ (idx_r << UNIT_SHIFT) + off_r);
		else
			buf_off = 48'(off) + 48'(idx) * 48'(d_stride);
	end

	// Final address and alignment
	logic [47:0] raw_addr;
	logic [47:0] mem_addr;
	logic [2:0]  need;
	logic        misaligned;
	logic        align_fault;

	always_comb begin
		raw_addr   = d_base + {16'h0, req.scalar_off} + buf_off;
		mem_addr   = raw_addr;
		need       = (req.size_log2 > 3'(UNIT_SHIFT)) ? 3'(UNIT_SHIFT) : req.size_log2;
		misaligned = (raw_addr[1:0] & 2'((3'h1 << need) - 3'h1)) != 2'h0;
		align_fault = 1'b0;
		if (!req.formatted) begin
			unique case (alignment_policy)
				ALIGN_WORD:        mem_addr[1:0] = raw_addr[1:0] & ~2'((3'h1 << need) - 3'h1);
				ALIGN_STRICT_WORD: align_fault = misaligned;
				ALIGN_STRICT:      align_fault = misaligned;
				ALIGN_NONE:        align_fault = 1'b0;
			endcase
			if (req.size_log2 >= 3'(UNIT_SHIFT))
				mem_addr[1:0] = 2'h0;
		end
	end

	// Local share address and its bound
	logic [31:0] local_addr;
	logic        local_ok;

	always_comb begin
		local_addr = (ls_base << LSHARE_GRAN_SH) + {16'h0, local_offset_register}
			+ {20'h0, req.imm_offset} + {24'h0, req.lane_index, 2'h0};
		local_ok = req.to_local_share && !req.fault_status_enable
			&& (local_addr >= (ls_base << LSHARE_GRAN_SH))
			&& (local_addr < ((ls_base + ls_size) << LSHARE_GRAN_SH));
	end

	// Write data narrowing for half-word and byte forms
	logic [31:0] wdata;

	always_comb begin
		wdata = req.data;
		if (req.half_word_high_variant)
			wdata = {16'h0000, req.data[31:16]};
		else if (req.half_word_low_variant)
			wdata = {16'h0000, req.data[15:0]};
		if (req.byte_load && (req.half_word_low_variant || req.half_word_high_variant))
			wdata = {16'h0000, 8'h00, wdata[7:0]};
	end

	// Cache policy selection
	bag_pol_t pol_l2;
	bag_pol_t pol_l1;
	bag_pol_t pol_l0;

	always_comb begin
		pol_l0 = req.bypass_first ? POL_MISS_EVICT : POL_HIT_LRU;
		if (req.op == OP_LOAD) begin
			unique case ({req.system_coherence_flag, req.device_coherence_flag})
				2'h0: begin pol_l2 = POL_LRU;         pol_l1 = POL_HIT_LRU;    end
				2'h1: begin pol_l2 = POL_LRU;         pol_l1 = POL_MISS_EVICT; end
				2'h2: begin pol_l2 = POL_STREAM;      pol_l1 = POL_HIT_LRU;    end
				2'h3: begin pol_l2 = POL_HIT_NOALLOC; pol_l1 = POL_MISS_EVICT; end
			endcase
		end else begin
			unique case ({req.system_coherence_flag, req.device_coherence_flag})
				2'h0: pol_l2 = POL_LRU;
				2'h1: pol_l2 = POL_BYPASS;
				2'h2: pol_l2 = POL_STREAM;
				2'h3: pol_l2 = POL_HIT_NOALLOC;
			endcase
			pol_l1 = POL_BYPASS;
			pol_l0 = POL_MISS_EVICT;
		end
	end

	// Registered result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_valid <= 1'b0;
			res       <= '0;
		end else begin
			res_valid <= req_valid;
			if (req_valid) begin
				res.mem_addr     <= mem_addr;
				res.local_addr   <= local_addr;
				res.local_ok     <= local_ok;
				res.unbound      <= d_unbound;
				res.align_fault  <= align_fault;
				res.return_data  <= (req.op == OP_LOAD) && !d_unbound
					|| (req.op == OP_ATOMIC) && req.bypass_first;
				res.first_invalidate <= (req.op == OP_LOAD) && req.bypass_first
					|| (req.op == OP_STORE);
				res.pol_l2       <= pol_l2;
				res.pol_l1       <= pol_l1;
				res.pol_l0       <= pol_l0;
				res.bounds_sel   <= d_bounds;
				res.is_buffer    <= (d_type == 2'h0);
				res.num_records  <= d_numrec;
				res.rec_in_bytes <= (d_stride == 14'h0000);
				res.sels         <= d_unbound ? 12'h000 : sels;
				res.wdata        <= wdata;
			end
		end
	end

	// Statistics shown in status
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_count   <= 32'h0000_0000;
			fault_count <= 32'h0000_0000;
		end else if (req_valid) begin
			req_count <= req_count + 32'h0000_0001;
			if (align_fault)
				fault_count <= fault_count + 32'h0000_0001;
		end
	end

	// AXI write channel capture
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Address ready, dropped on capture, raised again once the write response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_awready <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
			s_axi_awready <= 1'b0;
		else if (!aw_held && !s_axi_bvalid)
			s_axi_awready <= 1'b1;
	end

	// Data ready, same life cycle as the address ready
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_wready <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
			s_axi_wready <= 1'b0;
		else if (!w_held && !s_axi_bvalid)
			s_axi_wready <= 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// Register update and write response
	function automatic logic [31:0] bag_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction : bag_merge

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl         <= CTRL_RST;
			ls_base      <= 32'h0000_0000;
			ls_size      <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (aw_held && w_held) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				unique case (aw_addr)
					OFS_CTRL:   ctrl    <= bag_merge(ctrl, w_data, w_strb);
					OFS_LSBASE: ls_base <= bag_merge(ls_base, w_data, w_strb);
					OFS_LSSIZE: ls_size <= bag_merge(ls_size, w_data, w_strb);
					OFS_STATUS: s_axi_bresp <= RESP_SLVERR;
					default:    s_axi_bresp <= RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read address ready, dropped on capture, raised once the data is taken
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_axi_arready <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			s_axi_arready <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;
	end

	// Read channel

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_CTRL:   s_axi_rdata <= ctrl;
				OFS_STATUS: s_axi_rdata <= {fault_count[15:0], req_count[15:0]};
				OFS_LSBASE: s_axi_rdata <= ls_base;
				OFS_LSSIZE: s_axi_rdata <= ls_size;
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : bag_core

// ---- verif/bag_cache_model.sv ----
// Cache side sink that logs every lane result
`timescale 1ns/1ps
module bag_cache_model
	import bag_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Result stream
	input  wire logic res_valid,
	input  bag_res_t  res,
	// Observed traffic
	output int        n_res,
	output bag_res_t  last
);
	// Take each result in its single valid cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			n_res <= 0;
			last  <= '0;
		end else if (res_valid) begin
			n_res <= n_res + 1;
			last  <= res;
		end
	end
endmodule : bag_cache_model

// ---- verif/bag_core_assertions.sv ----
// Concurrent checks on the buffer address generator ports
`timescale 1ns/1ps
module bag_core_assertions
	import bag_pkg::*;
(
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Lane path
	input  wire logic req_valid,
	input  bag_req_t  req,
	input  wire logic res_valid,
	input  bag_res_t  res
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Result pulse follows each request by one cycle
	a_res_one_cycle: assert property (res_valid == $past(req_valid))
		else $error("res_valid timing wrong");
	a_store_l1_bypass: assert property (req_valid && req.op != OP_LOAD |=>
		res.pol_l1 == POL_BYPASS && res.pol_l0 == POL_MISS_EVICT) else $error("store policy wrong");
	a_atomic_ret_data: assert property (req_valid && req.op == OP_ATOMIC |=>
		res.return_data == $past(req.bypass_first)) else $error("atomic return wrong");
	a_load_bypass_inv: assert property (req_valid && req.op == OP_LOAD && req.bypass_first |=>
		res.first_invalidate && res.pol_l0 == POL_MISS_EVICT) else $error("bypass load wrong");
	a_desc_bounds_type: assert property (req_valid |=> res.bounds_sel == $past(req.desc[125:124])
		&& res.is_buffer == ($past(req.desc[127:126]) == 2'h0)) else $error("bounds/type wrong");
	a_rec_count_units: assert property (req_valid |=> res.num_records == $past(req.desc[95:64])
		&& res.rec_in_bytes == ($past(req.desc[61:48]) == 14'h0)) else $error("records wrong");
	a_unbound_zero: assert property (req_valid && req.desc == 128'h0 |=>
		res.unbound && res.sels == 12'h0) else $error("unbound wrong");
	a_half_high_data: assert property (req_valid && req.op == OP_STORE
		&& req.half_word_high_variant && !req.byte_load |=>
		res.wdata[15:0] == $past(req.data[31:16])) else $error("half high data wrong");
	// Main scenarios
	c_swizzled: cover property (req_valid && req.desc[63]);
	c_local: cover property (req_valid && req.to_local_share);
	c_atomic_ret: cover property (req_valid && req.op == OP_ATOMIC && req.bypass_first);
endmodule : bag_core_assertions

bind bag_core bag_core_assertions u_chk (
	.aclk      (aclk),
	.aresetn   (aresetn),
	.req_valid (req_valid),
	.req       (req),
	.res_valid (res_valid),
	.res       (res)
);

// ---- verif/bag_core_tb.sv ----
// Self-checking bench for the buffer address generator
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin fails++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module bag_core_tb
	import bag_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, rv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp;
	logic        awready, wready, bvalid, arready, rvalid, res_valid;
	bag_req_t    req, q;
	bag_res_t    res, last;
	int          n_res, fails, n_tests, n_req, seed;
	bag_pol_t    ld_l2[4] = '{POL_LRU, POL_LRU, POL_STREAM, POL_HIT_NOALLOC};
	bag_pol_t    ld_l1[4] = '{POL_HIT_LRU, POL_MISS_EVICT, POL_HIT_LRU, POL_MISS_EVICT};
	bag_pol_t    st_l2[4] = '{POL_LRU, POL_BYPASS, POL_STREAM, POL_HIT_NOALLOC};

	bag_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .req_valid(req_valid), .req(req), .res_valid(res_valid),
		.res(res));
	bag_cache_model cache_u (.aclk(aclk), .aresetn(aresetn), .res_valid(res_valid),
		.res(res), .n_res(n_res), .last(last));

	// Clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Address reckoned from the lane operands and descriptor
	function automatic logic [47:0] exp_addr(bag_req_t r);
		longint ix, of, grp, st, bo;
		logic [47:0] t;
		ix = (r.idx_from_reg ? r.lane_idx : 0) + (r.desc[119] ? r.lane_index : 0);
		of = (r.off_from_reg ? r.lane_off : 0) + r.imm_offset;
		st = r.desc[61:48];
		grp = 8 << r.desc[118:117];
		if (r.desc[63])
			bo = ((ix / grp) * st + (of / 4) * 4) * grp + (ix % grp) * 4 + of % 4;
		else
			bo = of + st * ix;
		t = 48'(r.desc[47:0] + r.scalar_off + bo);
		t[1:0] = 2'h0;
		return t;
	endfunction : exp_addr

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		// Each channel released right after the edge that takes it
		do begin
			@(posedge aclk);
			if (!ta && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (!tw && wready) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(ta && tw));
		// Response taken at the edge where bvalid is seen
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		// Address held until the edge that takes it
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		// Data taken at the edge where rvalid is seen
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic lane(input bag_req_t r);
		@(posedge aclk);
		req       <= r;
		req_valid <= 1'b1;
		n_req++;
		@(posedge aclk);
		req_valid <= 1'b0;
		@(negedge aclk);
		`CHK("res_valid", 1'b1, res_valid)
	endtask : lane

	task automatic results();
		$display("Counts: %0d checks, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// Watchdog
	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		results();
	end

	// Main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, req_valid} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		req = '0;
		seed = 32'h8f9d7061;
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(OFS_CTRL, rd, rsp);
		`CHK("ctrl_reset", CTRL_RST, rd)
		axi_wr(OFS_CTRL, 32'h00AB_0003, rsp);
		axi_rd(OFS_CTRL, rd, rsp);
		`CHK("ctrl_rd", 32'h00AB_0003, rd)
		axi_wr(OFS_STATUS, 32'h1, rsp);
		`CHK("status_wr", RESP_SLVERR, rsp)
		axi_rd(8'h10, rd, rsp);
		`CHK("unmapped", {RESP_SLVERR, 32'h0}, {rsp, rd})
		axi_wr(OFS_CTRL, 32'h0, rsp);
		$display("test registers done");
		for (int i = 0; i < 40; i++) begin
			rv = $random(seed);
			q = '0;
			q.size_log2 = 3'h2;
			q.idx_from_reg = rv[0];
			q.off_from_reg = rv[1];
			q.lane_index = rv[7:2];
			q.lane_idx = {24'h0, rv[15:8]};
			q.lane_off = {20'h0, rv[25:16], 2'h0};
			q.imm_offset = {rv[31:26], 6'h0};
			q.scalar_off = $random(seed) & 32'hFFFF;
			q.desc = {$random(seed), $random(seed), $random(seed), $random(seed)};
			q.desc[61:48] = q.desc[61:48] & 14'h3FFC;
			q.desc[127:126] = 2'h0;
			lane(q);
			`CHK("mem_addr", exp_addr(q), res.mem_addr)
			`CHK("num_records", q.desc[95:64], res.num_records)
			`CHK("rec_in_bytes", q.desc[61:48] == 14'h0, res.rec_in_bytes)
			`CHK("bounds_sel", q.desc[125:124], res.bounds_sel)
		end
		$display("test addressing done");
		axi_wr(OFS_LSBASE, 32'h2, rsp);
		axi_wr(OFS_LSSIZE, 32'h1, rsp);
		axi_wr(OFS_CTRL, 32'h0010_0000, rsp);
		for (int i = 0; i < 3; i++) begin
			q = '0;
			q.to_local_share = 1'b1;
			q.size_log2 = 3'h2;
			q.desc = 128'h1000;
			q.lane_index = (i == 1) ? 6'h3F : 6'h3;
			q.imm_offset = (i == 1) ? 12'hFC : 12'h4;
			q.fault_status_enable = (i == 2);
			lane(q);
			`CHK("local_addr", 32'h110 + q.imm_offset + q.lane_index * 4, res.local_addr)
			`CHK("local_ok", i == 0, res.local_ok)
			`CHK("ls_mem_addr", exp_addr(q), res.mem_addr)
		end
		$display("test local share done");
		for (int i = 0; i < 3; i++) begin
			q = '0;
			q.op = OP_STORE;
			q.size_log2 = 3'h1;
			q.desc = 128'h2000;
			q.data = 32'hBEEF_1234;
			q.half_word_low_variant = (i != 1);
			q.half_word_high_variant = (i == 1);
			q.byte_load = (i == 2);
			lane(q);
			`CHK("wdata", (i == 0) ? 16'h1234 : (i == 1) ? 16'hBEEF : 16'h34, res.wdata[15:0])
		end
		$display("test half word done");
		for (int m = 0; m < 4; m++) begin
			axi_wr(OFS_CTRL, 32'(m), rsp);
			q = '0;
			q.size_log2 = 3'h2;
			q.desc = 128'h3002;
			lane(q);
			`CHK("align_fault", m == 1 || m == 2, res.align_fault)
			if (m == 0) `CHK("auto_align", 48'h3000, res.mem_addr)
		end
		$display("test alignment done");
		for (int k = 0; k < 12; k++) begin
			q = '0;
			q.desc = 128'h4000;
			q.op = bag_op_t'(k / 4);
			{q.system_coherence_flag, q.device_coherence_flag} = 2'(k % 4);
			q.bypass_first = 1'(k / 2);
			lane(q);
			`CHK("pol_l2", (k < 4) ? ld_l2[k % 4] : st_l2[k % 4], res.pol_l2)
			`CHK("pol_l1", (k < 4) ? ld_l1[k % 4] : POL_BYPASS, res.pol_l1)
			`CHK("pol_l0", (k >= 4 || q.bypass_first) ? POL_MISS_EVICT : POL_HIT_LRU, res.pol_l0)
			`CHK("first_inv", (k < 4) ? q.bypass_first : (k < 8), res.first_invalidate)
			if (k >= 8) `CHK("return_data", q.bypass_first, res.return_data)
		end
		$display("test cache policy done");
		q = '0;
		lane(q);
		`CHK("unbound", 1'b1, res.unbound)
		for (int c = 0; c < 8; c++) begin
			q.desc = 128'h5000;
			q.desc[107:96] = {4{3'(c)}};
			lane(q);
			`CHK("sels", {4{(c == 2 || c == 3) ? 3'h0 : 3'(c)}}, res.sels)
		end
		// Cache model logs the last result one edge after it appears
		@(negedge aclk);
		`CHK("res_count", n_req, n_res)
		`CHK("last_res", res, last)
		axi_rd(OFS_STATUS, rd, rsp);
		`CHK("status", {16'h0002, 16'(n_req)}, rd)
		$display("test descriptor done");
		results();
	end
endmodule : bag_core_tb
